// file: eppc_pkg.sv
// package: constants and types for the eprom programming control block
package eppc_pkg;
  // ----------------------------------------
  // register map (apb byte addresses)
  // ----------------------------------------
  localparam logic [7:0] EPPC_CTRL_OFS   = 8'h00;
  localparam logic [7:0] EPPC_PWIDTH_OFS = 8'h04;
  localparam logic [7:0] EPPC_ADDR_OFS   = 8'h08;
  localparam logic [7:0] EPPC_DATA_OFS   = 8'h0c;
  localparam logic [7:0] EPPC_CFG_OFS    = 8'h10;
  localparam logic [7:0] EPPC_KEY_OFS    = 8'h14;
  localparam logic [7:0] EPPC_STAT_OFS   = 8'h18;
  localparam logic [7:0] EPPC_RDATA_OFS  = 8'h1c;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int EPPC_CTRL_MODE_LSB  = 0;
  localparam int EPPC_CTRL_START_BIT = 4;
  localparam int EPPC_CTRL_VERIFY_BIT = 5;
  localparam int EPPC_CTRL_INCR_BIT  = 6;
  localparam int EPPC_CFG_RLOCK_BIT  = 2;
  localparam int EPPC_CFG_WLOCK_BIT  = 3;
  localparam int EPPC_STAT_BUSY_BIT  = 0;
  localparam int EPPC_STAT_KEYOK_BIT = 1;
  localparam int EPPC_STAT_DENY_BIT  = 2;
  localparam int EPPC_STAT_DONE_BIT  = 3;
  // ----------------------------------------
  // reset values and addresses
  // ----------------------------------------
  localparam logic [15:0] EPPC_PWIDTH_RST = 16'h0100;
  localparam logic [7:0]  EPPC_CFG_RST    = 8'hff;
  localparam logic [15:0] EPPC_PWIDTH_LOC = 16'h4014;
  localparam logic [15:0] EPPC_NODUMP_LO  = 16'h9000;
  localparam logic [15:0] EPPC_NODUMP_HI  = 16'h91ff;
  localparam logic [15:0] EPPC_SIG_ADDR   = 16'h2070;
  localparam logic [15:0] EPPC_VPP_ADDR0  = 16'h2072;
  localparam logic [15:0] EPPC_VPP_ADDR1  = 16'h2074;
  // ----------------------------------------
  // timing: verify access time
  // ----------------------------------------
  localparam int EPPC_CLK_MHZ       = 125;
  localparam int EPPC_VERIFY_NS     = 80;
  localparam int EPPC_VERIFY_CYC    = (EPPC_VERIFY_NS * EPPC_CLK_MHZ + 999) / 1000;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    EPPC_MODE_IDLE,
    EPPC_MODE_AUTO,
    EPPC_MODE_AUTO_CFG,
    EPPC_MODE_SLAVE,
    EPPC_MODE_RUNTIME,
    EPPC_MODE_DUMP
  } eppc_mode_t;
  typedef enum {
    EPPC_ST_IDLE,
    EPPC_ST_KEY,
    EPPC_ST_PULSE,
    EPPC_ST_VERIFY,
    EPPC_ST_DONE
  } eppc_state_t;
endpackage

// file: eppc_ctrl.sv
// eprom programming control: apb registers, security check, pulse timer
//
// Function
// - programming pulse length comes from pulse_width_reg in auto, auto-config, run-time modes
// - in slave mode addr_auto_incr advances the address without new command
// - locked config byte forces security key check in auto, auto-config, slave modes
// - on a locked part in auto, auto-config or slave mode, program and verify proceed only when supplied key matches stored key
// - dump mode drives no data for addresses 9000h to 91ffh
// - two readable words after signature encode the programming voltage
// - prog_active shares port2_bit7, addr_auto_incr shares port2_bit4
// - no gang programming master mode and no signals for it
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module eppc_ctrl
  import eppc_pkg::*;
#(
  parameter int          ADDR_W    = 16,
  parameter int          KEY_W     = 32,
  parameter logic [31:0] STORED_KEY = 32'h5a5a_a5a5, // arbitrary value
  parameter logic [15:0] VPP_CODE0  = 16'h00c8,      // arbitrary value
  parameter logic [15:0] VPP_CODE1  = 16'h0000       // arbitrary value
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        port2_bit4_in,
  output var  logic        port2_bit7_out,
  output var  logic        port2_bit7_oe,
  output var  logic        prog_strobe,
  output var  logic [15:0] prog_addr,
  output var  logic [15:0] prog_wdata,
  output var  logic        dump_data_oe
);
  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (ADDR_W != 16) begin : g_bad_aw
    $error("eppc_ctrl: ADDR_W must be 16");
  end
  if (KEY_W < 1 || KEY_W > 32) begin : g_bad_kw
    $error("eppc_ctrl: KEY_W must be 1..32");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  eppc_mode_t        mode_r;
  eppc_state_t       state_r;
  logic [15:0]       pulse_width_reg_r;
  logic [15:0]       addr_r;
  logic [15:0]       data_r;
  logic [7:0]        chip_config_byte_r;
  logic [KEY_W-1:0]  key_r;
  logic              key_ok_r;
  logic              deny_r;
  logic              done_r;
  logic              verify_req_r;
  logic              start_pulse;
  logic              incr_pulse;
  logic [15:0]       cnt_r;
  logic [15:0]       rdata_r;
  logic [2:0]        incr_sync_r;
  logic              incr_level_r;
  logic              incr_edge;
  logic              wr_en;
  logic              rd_en;
  logic [7:0]        ofs;

  function automatic logic locked(input logic [7:0] cfg_byte);
    // programmed (zero) lock bit means locked
    locked = !cfg_byte[EPPC_CFG_RLOCK_BIT] || !cfg_byte[EPPC_CFG_WLOCK_BIT];
  endfunction

  function automatic logic timed_mode(input eppc_mode_t m);
    timed_mode = (m == EPPC_MODE_AUTO) || (m == EPPC_MODE_AUTO_CFG)
              || (m == EPPC_MODE_RUNTIME);
  endfunction

  assign ofs   = paddr[7:0];
  // upper address bits must be zero, else the write would alias a register
  assign wr_en = psel && penable && pwrite && paddr[31:8] == 24'h0;
  assign rd_en = psel && !penable && !pwrite;
  assign start_pulse = wr_en && ofs == EPPC_CTRL_OFS && pwdata[EPPC_CTRL_START_BIT];
  assign incr_pulse  = wr_en && ofs == EPPC_CTRL_OFS && pwdata[EPPC_CTRL_INCR_BIT];

  // ----------------------------------------
  // apb: zero wait, errors on unmapped offsets
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && (ofs > EPPC_RDATA_OFS || ofs[1:0] != 2'b00
                 || paddr[31:8] != 24'h0);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_en) begin
      case (ofs)
        EPPC_CTRL_OFS:  prdata <= {29'h0, mode_r};
        EPPC_PWIDTH_OFS: prdata <= {16'h0, pulse_width_reg_r};
        EPPC_ADDR_OFS:  prdata <= {16'h0, addr_r};
        EPPC_DATA_OFS:  prdata <= {16'h0, data_r};
        EPPC_CFG_OFS:   prdata <= {24'h0, chip_config_byte_r};
        EPPC_KEY_OFS:   prdata <= 32'h0;
        EPPC_STAT_OFS:  prdata <= {28'h0, done_r, deny_r, key_ok_r, state_r != EPPC_ST_IDLE};
        EPPC_RDATA_OFS: prdata <= {16'h0, rdata_r};
        default:        prdata <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------
  // software-written registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r             <= EPPC_MODE_IDLE;
      pulse_width_reg_r  <= EPPC_PWIDTH_RST;
      data_r             <= 16'h0;
      chip_config_byte_r <= EPPC_CFG_RST;
      key_r              <= '0;
    end else if (wr_en && state_r == EPPC_ST_IDLE) begin
      case (ofs)
        EPPC_CTRL_OFS: begin
          // gang master mode codes are not decoded
          if (pwdata[2:0] <= 3'h5) begin
            mode_r <= eppc_mode_t'(pwdata[2:0]);
          end
        end
        EPPC_PWIDTH_OFS: pulse_width_reg_r  <= pwdata[15:0];
        EPPC_DATA_OFS:   data_r             <= pwdata[15:0];
        EPPC_CFG_OFS:    chip_config_byte_r <= pwdata[7:0];
        EPPC_KEY_OFS:  key_r              <= pwdata[KEY_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // auto-increment pin sync (three stages)
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      incr_sync_r  <= 3'b000;
      incr_level_r <= 1'b0;
    end else begin
      incr_sync_r <= {incr_sync_r[1:0], port2_bit4_in};
      if (incr_sync_r[1] == incr_sync_r[2]) begin
        incr_level_r <= incr_sync_r[2];
      end
    end
  end
  assign incr_edge = incr_sync_r[1] && incr_sync_r[2] && !incr_level_r;

  // ----------------------------------------
  // address counter
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_r <= 16'h0;
    end else if (wr_en && ofs == EPPC_ADDR_OFS && state_r == EPPC_ST_IDLE) begin
      addr_r <= pwdata[15:0];
    end else if (mode_r == EPPC_MODE_SLAVE && state_r == EPPC_ST_IDLE
                 && (incr_edge || incr_pulse)) begin
      addr_r <= addr_r + 16'h0002;
    end
  end

  // ----------------------------------------
  // operation sequencer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r      <= EPPC_ST_IDLE;
      cnt_r        <= 16'h0;
      key_ok_r     <= 1'b0;
      deny_r       <= 1'b0;
      done_r       <= 1'b0;
      verify_req_r <= 1'b0;
    end else begin
      case (state_r)
        EPPC_ST_IDLE: begin
          if (start_pulse && mode_r != EPPC_MODE_IDLE && mode_r != EPPC_MODE_DUMP) begin
            verify_req_r <= pwdata[EPPC_CTRL_VERIFY_BIT];
            done_r       <= 1'b0;
            deny_r       <= 1'b0;
            if (mode_r != EPPC_MODE_RUNTIME && locked(chip_config_byte_r)) begin
              state_r <= EPPC_ST_KEY;
            end else begin
              state_r <= pwdata[EPPC_CTRL_VERIFY_BIT] ? EPPC_ST_VERIFY : EPPC_ST_PULSE;
              cnt_r   <= pwdata[EPPC_CTRL_VERIFY_BIT] ? 16'(EPPC_VERIFY_CYC)
                                                      : pulse_width_reg_r;
            end
          end
        end
        EPPC_ST_KEY: begin
          key_ok_r <= key_r == STORED_KEY[KEY_W-1:0];
          if (key_r == STORED_KEY[KEY_W-1:0]) begin
            state_r <= verify_req_r ? EPPC_ST_VERIFY : EPPC_ST_PULSE;
            cnt_r   <= verify_req_r ? 16'(EPPC_VERIFY_CYC) : pulse_width_reg_r;
          end else begin
            deny_r  <= 1'b1;
            state_r <= EPPC_ST_DONE;
          end
        end
        EPPC_ST_PULSE, EPPC_ST_VERIFY: begin
          if (cnt_r <= 16'h0001) begin
            state_r <= EPPC_ST_DONE;
          end else begin
            cnt_r <= cnt_r - 16'h0001;
          end
        end
        EPPC_ST_DONE: begin
          done_r  <= 1'b1;
          state_r <= EPPC_ST_IDLE;
        end
        default: state_r <= EPPC_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // verify readback: voltage words, data word at every other address
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r <= 16'h0;
    end else if (state_r == EPPC_ST_VERIFY && cnt_r <= 16'h0001) begin
      case (addr_r)
        EPPC_VPP_ADDR0: rdata_r <= VPP_CODE0;
        EPPC_VPP_ADDR1: rdata_r <= VPP_CODE1;
        default:        rdata_r <= data_r;
      endcase
    end
  end

  // ----------------------------------------
  // pins and array strobes
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port2_bit7_out <= 1'b0;
      port2_bit7_oe  <= 1'b0;
      prog_strobe    <= 1'b0;
      prog_addr      <= 16'h0;
      prog_wdata     <= 16'h0;
      dump_data_oe   <= 1'b0;
    end else begin
      // high only while an operation is under way
      port2_bit7_out <= state_r == EPPC_ST_PULSE || state_r == EPPC_ST_VERIFY
                     || state_r == EPPC_ST_KEY;
      port2_bit7_oe  <= mode_r != EPPC_MODE_IDLE;
      prog_strobe    <= state_r == EPPC_ST_PULSE && timed_mode(mode_r) || 
                        state_r == EPPC_ST_PULSE && mode_r == EPPC_MODE_SLAVE;
      prog_addr      <= addr_r;
      prog_wdata     <= data_r;
      // the hole stays undriven so the external bus floats there
      dump_data_oe   <= mode_r == EPPC_MODE_DUMP
                     && !(addr_r >= EPPC_NODUMP_LO && addr_r <= EPPC_NODUMP_HI);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_dump_hole_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_r == EPPC_MODE_DUMP && addr_r >= EPPC_NODUMP_LO && addr_r <= EPPC_NODUMP_HI)
    |=> !dump_data_oe)
    else $error("dump drove data inside protected range");
  chk_key_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == EPPC_ST_KEY && key_r != STORED_KEY[KEY_W-1:0]) |=> state_r == EPPC_ST_DONE)
    else $error("bad key did not end operation");
  chk_lock_check: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == EPPC_ST_IDLE && start_pulse && (mode_r == EPPC_MODE_AUTO
     || mode_r == EPPC_MODE_AUTO_CFG || mode_r == EPPC_MODE_SLAVE)
     && locked(chip_config_byte_r)) |=> state_r == EPPC_ST_KEY)
    else $error("locked part skipped key check");
  chk_pulse_len: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == EPPC_ST_IDLE && start_pulse && timed_mode(mode_r)
     && !locked(chip_config_byte_r) && !pwdata[EPPC_CTRL_VERIFY_BIT])
    |=> cnt_r == $past(pulse_width_reg_r))
    else $error("pulse not loaded from width register");
  chk_active_pin: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == EPPC_ST_PULSE) |=> port2_bit7_out)
    else $error("active pin low during pulse");
  chk_active_drop: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == EPPC_ST_DONE) |=> !port2_bit7_out)
    else $error("active pin held after finish");
  chk_auto_incr: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_r == EPPC_MODE_SLAVE && state_r == EPPC_ST_IDLE && incr_pulse
     && !(wr_en && ofs == EPPC_ADDR_OFS)) |=> addr_r == $past(addr_r) + 16'h0002)
    else $error("address did not advance");
  chk_vpp_word: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == EPPC_ST_VERIFY && cnt_r <= 16'h0001 && addr_r == EPPC_VPP_ADDR0)
    |=> rdata_r == VPP_CODE0)
    else $error("voltage word wrong");
endmodule
`default_nettype wire

// file: eppc_host_model.sv
// programming host model: auto-increment pin driver and strobe observer
`timescale 1ns/100ps
`default_nettype none
module eppc_host_model
  import eppc_pkg::*;
#(
  parameter logic [15:0] HOST_PWIDTH = 16'h0007
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        incr_req,
  input  wire logic        prog_strobe,
  input  wire logic        pin_bit7,
  output var  logic        port2_bit4,
  output var  logic [15:0] ext_pwidth,
  output var  logic [15:0] pulse_len,
  output var  logic [7:0]  n_pulses,
  output var  logic [15:0] n_active
);
  logic [2:0]  hold_r;
  logic        prev_r;
  logic [15:0] run_r;
  // ----------------------------------------
  // external word at the pulse-width location
  // ----------------------------------------
  assign ext_pwidth = HOST_PWIDTH;
  // ----------------------------------------
  // auto-increment pulse, held past the 3-ff sync
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_r     <= 3'h0;
      port2_bit4 <= 1'b0;
    end else if (incr_req) begin
      hold_r     <= 3'h4;
      port2_bit4 <= 1'b1;
    end else if (hold_r != 3'h0) begin
      hold_r     <= hold_r - 3'h1;
      port2_bit4 <= (hold_r != 3'h1);
    end
  end
  // ----------------------------------------
  // strobe width and active-pin observation
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r    <= 1'b0;
      run_r     <= 16'h0;
      pulse_len <= 16'h0;
      n_pulses  <= 8'h0;
      n_active  <= 16'h0;
    end else begin
      prev_r <= prog_strobe;
      if (prog_strobe) run_r <= prev_r ? run_r + 16'h1 : 16'h1;
      if (!prog_strobe && prev_r) pulse_len <= run_r;
      if (prog_strobe && !prev_r) n_pulses <= n_pulses + 8'h1;
      if (pin_bit7) n_active <= n_active + 16'h1;
    end
  end
endmodule
`default_nettype wire

// file: tb_eprom_program_control.sv
// testbench for the eprom programming control block
`timescale 1ns/100ps
`default_nettype none
module tb_eprom_program_control;
  import eppc_pkg::*;
  localparam logic [31:0] KEY_OK = 32'h5a5a_a5a5; // arbitrary value
  localparam logic [15:0] VPP0   = 16'h00c8;      // arbitrary value
  localparam logic [15:0] VPP1   = 16'h0a0a;      // arbitrary value
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rdata;
  logic        pready, pslverr, rerr, bit4, out7, oe7, pin7, strobe, dump_oe, incr_req = 1'b0;
  logic [15:0] prog_addr, prog_wdata, ext_pwidth, pulse_len, n_active;
  logic [7:0]  n_pulses;
  int          errors = 0, n_checks = 0;
  always #4 pclk = ~pclk;
  // undriven pin sits at its weak pull-up
  assign pin7 = oe7 ? out7 : 1'b1;
  eppc_ctrl #(.STORED_KEY(KEY_OK), .VPP_CODE0(VPP0), .VPP_CODE1(VPP1)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port2_bit4_in(bit4), .port2_bit7_out(out7), .port2_bit7_oe(oe7), .prog_strobe(strobe),
    .prog_addr(prog_addr), .prog_wdata(prog_wdata), .dump_data_oe(dump_oe));
  eppc_host_model host (
    .pclk(pclk), .presetn(presetn), .incr_req(incr_req), .prog_strobe(strobe),
    .pin_bit7(pin7), .port2_bit4(bit4), .ext_pwidth(ext_pwidth), .pulse_len(pulse_len),
    .n_pulses(n_pulses), .n_active(n_active));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {24'h0, a}; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) errors++;
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // software polls status rather than spinning on the pulse itself
  task automatic wait_done();
    int i;
    i = 0;
    do begin apb(1'b0, EPPC_STAT_OFS, 32'h0); i++; end while (rdata[0] !== 1'b0 && i < 60);
    // one more edge so the host model has seen the strobe fall
    @(posedge pclk);
    chk({31'h0, rdata[EPPC_STAT_DONE_BIT]}, 32'h1);
  endtask
  task automatic wrap_up();
    if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    apb(1'b0, EPPC_PWIDTH_OFS, 32'h0);
    chk(rdata, {16'h0, EPPC_PWIDTH_RST});
    apb(1'b0, EPPC_CFG_OFS, 32'h0);
    chk(rdata, {24'h0, EPPC_CFG_RST});
    apb(1'b0, 8'h20, 32'h0);         chk({31'h0, rerr}, 32'h1);
  endtask
  task automatic t_pulse();
    logic [2:0] modes [3] = '{3'd1, 3'd2, 3'd4};
    logic [15:0] pw, a0;
    for (int k = 0; k < 3; k++) begin
      pw = (k == 0) ? ext_pwidth : 16'(3 + 2 * k);
      apb(1'b1, EPPC_PWIDTH_OFS, {16'h0, pw});
      apb(1'b1, EPPC_CTRL_OFS, {29'h0, modes[k]});
      // output enable follows the mode write by one edge
      repeat (2) @(posedge pclk);
      chk({31'h0, oe7}, 32'h1);
      a0 = n_active;
      apb(1'b1, EPPC_CTRL_OFS, {25'h0, 4'h2, modes[k]});
      wait_done();
      chk({16'h0, pulse_len}, {16'h0, pw});
      chk({31'h0, (n_active - a0) >= pw}, 32'h1);
      chk({31'h0, out7}, 32'h0);
    end
  endtask
  task automatic t_lock();
    logic [7:0] cfgs [2] = '{8'hfb, 8'hf7};
    logic [7:0] p0;
    apb(1'b1, EPPC_PWIDTH_OFS, 32'h4);
    apb(1'b1, EPPC_CTRL_OFS, 32'h1);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, EPPC_CFG_OFS, {24'h0, cfgs[k]});
      apb(1'b1, EPPC_KEY_OFS, ~KEY_OK);
      p0 = n_pulses;
      apb(1'b1, EPPC_CTRL_OFS, 32'h11);
      wait_done();
      chk({31'h0, rdata[EPPC_STAT_DENY_BIT]}, 32'h1);
      chk({24'h0, n_pulses}, {24'h0, p0});
      apb(1'b1, EPPC_KEY_OFS, KEY_OK);
      apb(1'b1, EPPC_CTRL_OFS, 32'h11);
      wait_done();
      chk({30'h0, rdata[EPPC_STAT_DENY_BIT], rdata[EPPC_STAT_KEYOK_BIT]}, 32'h1);
      chk({24'h0, n_pulses}, {24'h0, p0 + 8'h1});
    end
    apb(1'b1, EPPC_CFG_OFS, 32'hff);
  endtask
  task automatic t_incr();
    int i;
    apb(1'b1, EPPC_CTRL_OFS, 32'h3);
    apb(1'b1, EPPC_ADDR_OFS, 32'h1000);
    incr_req <= 1'b1;
    @(posedge pclk);
    incr_req <= 1'b0;
    i = 0;
    do begin @(posedge pclk); i++; end while (prog_addr !== 16'h1002 && i < 16);
    chk({16'h0, prog_addr}, 32'h1002);
    apb(1'b1, EPPC_CTRL_OFS, 32'h43);
    repeat (2) @(posedge pclk);
    chk({16'h0, prog_addr}, 32'h1004);
  endtask
  task automatic t_dump();
    logic [15:0] ad [4] = '{16'h8ffe, 16'h9000, 16'h91ff, 16'h9200};
    apb(1'b1, EPPC_CTRL_OFS, 32'h5);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, EPPC_ADDR_OFS, {16'h0, ad[k]});
      repeat (2) @(posedge pclk);
      chk({31'h0, dump_oe}, {31'h0, (ad[k] < EPPC_NODUMP_LO || ad[k] > EPPC_NODUMP_HI)});
    end
    apb(1'b1, EPPC_CTRL_OFS, 32'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, oe7}, 32'h0);
    // an undecoded mode code must leave the mode unchanged
    apb(1'b1, EPPC_CTRL_OFS, 32'h6);
    apb(1'b0, EPPC_CTRL_OFS, 32'h0);
    chk(rdata, 32'h0);
  endtask
  task automatic t_vpp();
    apb(1'b1, EPPC_CTRL_OFS, 32'h3);
    // plain data word differs from both voltage words
    apb(1'b1, EPPC_DATA_OFS, 32'h5aa5);
    repeat (2) @(posedge pclk);
    chk({16'h0, prog_wdata}, 32'h5aa5);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, EPPC_ADDR_OFS, {16'h0, (k == 0) ? EPPC_VPP_ADDR0 : EPPC_VPP_ADDR1});
      apb(1'b1, EPPC_CTRL_OFS, 32'h33);
      wait_done();
      apb(1'b0, EPPC_RDATA_OFS, 32'h0);
      chk(rdata, {16'h0, (k == 0) ? VPP0 : VPP1});
    end
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_pulse();
    t_lock();
    t_incr();
    t_dump();
    t_vpp();
    wrap_up();
  end
  initial begin
    #(20000 * 8);
    errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
